// [pkg/sfcp_pkg.sv]
// Shared constants and types of the serial flash command front end.
// Assumes a 200 MHz core clock; the serial clock comes from the host.
package sfcp_pkg;
  // Opcodes.
  localparam logic [7:0] OP_LP_READ   = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT  = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO   = 8'hBB;
  localparam logic [7:0] OP_PAGE_CLR  = 8'h81;
  localparam logic [7:0] OP_4K_CLR    = 8'h20;
  localparam logic [7:0] OP_HALF_BLK  = 8'h52;
  localparam logic [7:0] OP_FULL_BLK  = 8'hD8;
  localparam logic [7:0] OP_CHIP_A    = 8'h60;
  localparam logic [7:0] OP_CHIP_B    = 8'hC7;
  localparam logic [7:0] OP_PAGE_WR   = 8'h02;
  localparam logic [7:0] OP_ARM       = 8'h06;
  localparam logic [7:0] OP_DISARM    = 8'h04;
  localparam logic [7:0] OP_VARM      = 8'h50;
  localparam logic [7:0] OP_ST_RD     = 8'h05;
  localparam logic [7:0] OP_CF_RD     = 8'h15;
  localparam logic [7:0] OP_ST_WR     = 8'h01;
  localparam logic [7:0] OP_CF_WR     = 8'h11;
  localparam logic [7:0] OP_RST_ARM   = 8'h66;
  localparam logic [7:0] OP_RST       = 8'h99;
  localparam logic [7:0] OP_ID_RD     = 8'h9F;
  localparam logic [7:0] OP_MD_ID     = 8'h90;
  localparam logic [7:0] OP_SLEEP     = 8'hB9;
  localparam logic [7:0] OP_WAKE      = 8'hAB;
  // Register fields and values after reset.
  localparam int         B_BUSY = 0;
  localparam int         B_WEL  = 1;
  localparam int         B_LOCK = 7;
  localparam int         B_DC   = 7;
  localparam logic [7:0] ST_RST = 8'h00;
  localparam logic [7:0] CF_RST = 8'h00;
  // Serial clock counts at which frame phases end.
  localparam logic [7:0] N_OPC   = 8'd8;
  localparam logic [7:0] N_DATA1 = 8'd16;
  localparam logic [7:0] N_ADR1  = 8'd32;
  localparam logic [7:0] N_ADR2  = 8'd20;
  localparam logic [7:0] N_DMY   = 8'd8;
  localparam logic [7:0] N_DMY_S = 8'd4;
  // Densities.
  localparam int DEN_512K = 0;
  localparam int DEN_1M   = 1;
  localparam int DEN_2M   = 2;
  // Self-timed operation times.
  localparam int CLK_MHZ    = 200;
  localparam int T_PROG_MS  = 2;
  localparam int T_ERASE_MS = 8;
  localparam int T_STW_MS   = 8;
  localparam int CYC_PROG   = T_PROG_MS * CLK_MHZ * 1000;
  localparam int CYC_ERASE  = T_ERASE_MS * CLK_MHZ * 1000;
  localparam int CYC_STW    = T_STW_MS * CLK_MHZ * 1000;
  typedef enum logic [2:0] {
    K_NONE = 3'b000, K_PROG = 3'b001, K_PAGE = 3'b010, K_4K = 3'b011,
    K_32K = 3'b100, K_64K = 3'b101, K_CHIP = 3'b110, K_REG = 3'b111
  } sfcp_kind_t;
  typedef enum logic [1:0] {
    L_OPC = 2'b00, L_ACT = 2'b01, L_STBY = 2'b10
  } sfcp_lst_t;
endpackage

// [design/sfcp_top.sv]
// Serial flash command front end: decode, protection and busy timing.
// Assumes sclk/cs_n/io from the host, and an array read port on sclk.
module sfcp_top
  import sfcp_pkg::*;
#(
  parameter int          DENSITY     = DEN_2M,
  parameter int          CYC_PROG_P  = CYC_PROG,
  parameter int          CYC_ERASE_P = CYC_ERASE,
  parameter int          CYC_STW_P   = CYC_STW,
  parameter logic [7:0]  MFR_ID      = 8'h5A,   // Arbitrary value.
  parameter logic [15:0] DEV_ID      = 16'hC3E1, // Arbitrary value.
  parameter logic [7:0]  ELEC_ID     = 8'h27    // Arbitrary value.
) (
  // Core clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // Serial link.
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        io0_i,
  output logic             io0_o,
  output logic             io0_oe,
  input  wire logic        io1_i,
  output logic             io1_o,
  output logic             io1_oe,
  input  wire logic        write_guard_pin_n,
  // Array read port, sclk domain.
  output logic [23:0]      array_raddr,
  input  wire logic [7:0]  array_rdata,
  // Array operation requests and state, ref_clk domain.
  output logic             op_start,
  output logic [2:0]       op_kind,
  output logic [23:0]      op_addr,
  output logic [7:0]       status_byte,
  output logic [7:0]       config_byte,
  output logic             deep_sleep
);
  function automatic logic is_rd(input logic [7:0] op);
    is_rd = op inside {OP_LP_READ, OP_FAST_READ, OP_DUAL_OUT, OP_DUAL_IO, OP_ST_RD,
                       OP_CF_RD, OP_ID_RD, OP_MD_ID, OP_WAKE};
  endfunction

  function automatic sfcp_kind_t op_kind_of(input logic [7:0] op);
    case (op)
      OP_PAGE_WR:           op_kind_of = K_PROG;
      OP_PAGE_CLR:          op_kind_of = K_PAGE;
      OP_4K_CLR:            op_kind_of = K_4K;
      OP_HALF_BLK:          op_kind_of = K_32K;
      OP_FULL_BLK:          op_kind_of = K_64K;
      OP_CHIP_A, OP_CHIP_B: op_kind_of = K_CHIP;
      OP_ST_WR, OP_CF_WR:   op_kind_of = K_REG;
      default:              op_kind_of = K_NONE;
    endcase
  endfunction

  // Serial clock count at which read data starts.
  function automatic logic [7:0] dstart(input logic [7:0] op, input logic dc);
    case (op)
      OP_LP_READ, OP_MD_ID, OP_WAKE: dstart = N_ADR1;
      OP_FAST_READ, OP_DUAL_OUT:     dstart = N_ADR1 + N_DMY;
      OP_DUAL_IO:                    dstart = N_ADR2 + (dc ? N_DMY : N_DMY_S);
      default:                       dstart = N_OPC;
    endcase
  endfunction

  // Protected range as {enable, low, high}.
  function automatic logic [48:0] prot_rng(input logic [4:0] bp);
    logic [23:0] top;
    logic [23:0] sz;
    top = 24'h010000 << DENSITY;
    sz  = 24'h000000;
    if (!bp[4]) begin
      case (DENSITY)
        DEN_2M: begin
          case (bp[1:0])
            2'b01:   sz = 24'h010000;
            2'b10:   sz = 24'h020000;
            2'b11:   sz = top;
            default: sz = 24'h000000;
          endcase
        end
        DEN_1M:  sz = bp[1] ? top : (bp[0] ? 24'h010000 : 24'h000000);
        default: sz = bp[0] ? top : 24'h000000;
      endcase
    end else begin
      case (bp[2:0])
        3'b000:  sz = 24'h000000;
        3'b001:  sz = 24'h001000;
        3'b010:  sz = 24'h002000;
        3'b011:  sz = 24'h004000;
        3'b111:  sz = top;
        default: sz = 24'h008000;
      endcase
    end
    prot_rng = {sz != 24'h000000, bp[3] ? 24'h000000 : top - sz,
                bp[3] ? sz - 24'h000001 : top - 24'h000001};
  endfunction

  function automatic logic [23:0] tmask(input sfcp_kind_t k);
    case (k)
      K_PROG, K_PAGE: tmask = 24'h0000FF;
      K_4K:           tmask = 24'h000FFF;
      K_32K:          tmask = 24'h007FFF;
      K_64K:          tmask = 24'h00FFFF;
      default:        tmask = 24'hFFFFFF;
    endcase
  endfunction

  // Link domain: frame capture on the host clock.
  logic        fresh_q;
  logic        tog_q;
  logic [7:0]  n_q;
  logic [2:0]  b3_q;
  logic [23:0] sh_q;
  logic [7:0]  op_q;
  logic [23:0] addr_q;
  logic [7:0]  dat_q;
  logic [23:0] rptr_q;
  logic [9:0]  sy1_q;
  logic [9:0]  sy2_q;
  sfcp_lst_t   lst_q;
  logic [7:0]  osh_q;
  logic [2:0]  obit_q;
  logic [1:0]  idx_q;
  logic        oe_q;
  logic        ld_q;
  logic [7:0]  st_q;
  logic [7:0]  cfg_q;
  logic        deep_q;

  wire        dual_in = !fresh_q && op_q == OP_DUAL_IO && n_q >= N_OPC && n_q < N_ADR2;
  wire [7:0]  n_nx    = fresh_q ? 8'd1 : (n_q == 8'hFF ? n_q : n_q + 8'd1);
  wire [23:0] sh_nx   = dual_in ? {sh_q[21:0], io1_i, io0_i} : {sh_q[22:0], io0_i};
  wire        l_busy  = sy2_q[B_BUSY];
  wire        l_deep  = sy2_q[9];

  // Chip select high marks each new frame.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  // Frame toggle tells the core domain that a frame had clock edges.
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      tog_q <= 1'b0;
    end else if (fresh_q && !cs_n) begin
      tog_q <= ~tog_q;
    end
  end

  // Core state brought onto the serial clock.
  always_ff @(posedge sclk) begin
    sy1_q <= {deep_q, cfg_q[B_DC], st_q};
    sy2_q <= sy1_q;
  end

  // Input bits are sampled on the rising edge.
  always_ff @(posedge sclk) begin
    n_q  <= n_nx;
    b3_q <= fresh_q ? 3'd1 : b3_q + 3'd1;
    sh_q <= sh_nx;
    if (n_nx == N_OPC) begin
      op_q <= sh_nx[7:0];
    end
    if (n_nx == N_DATA1) begin
      dat_q <= sh_nx[7:0];
    end
    if ((n_nx == N_ADR1 && op_q != OP_DUAL_IO) || (n_nx == N_ADR2 && op_q == OP_DUAL_IO)) begin
      addr_q <= sh_nx;
      rptr_q <= sh_nx;
    end else if (ld_q) begin
      rptr_q <= rptr_q + 24'd1;
    end
  end

  // Opcode check decides between active and standby.
  always_ff @(posedge sclk) begin
    if (fresh_q) begin
      lst_q <= L_OPC;
    end else if (n_nx == N_OPC) begin
      if (op_kind_of(sh_nx[7:0]) == K_NONE && !is_rd(sh_nx[7:0]) &&
          !(sh_nx[7:0] inside {OP_ARM, OP_DISARM, OP_VARM, OP_RST_ARM, OP_RST, OP_SLEEP})) begin
        lst_q <= L_STBY;
      end else if (l_deep && sh_nx[7:0] != OP_WAKE) begin
        lst_q <= L_STBY;
      end else if (l_busy && (op_kind_of(sh_nx[7:0]) != K_NONE ||
                   sh_nx[7:0] inside {OP_LP_READ, OP_FAST_READ, OP_DUAL_OUT, OP_DUAL_IO})) begin
        lst_q <= L_STBY;
      end else begin
        lst_q <= L_ACT;
      end
    end
  end

  wire [7:0] ds     = dstart(op_q, sy2_q[8]);
  wire       dual_o = op_q == OP_DUAL_OUT || op_q == OP_DUAL_IO;
  wire       run    = !fresh_q && lst_q == L_ACT && is_rd(op_q) && n_q >= ds;
  wire       first  = n_q == ds;
  wire       lastb  = dual_o ? obit_q == 3'd3 : obit_q == 3'd7;
  wire [1:0] idx_nx = first ? 2'd0 : idx_q + 2'd1;
  logic [7:0] src;

  always_comb begin
    case (op_q)
      OP_ST_RD: src = sy2_q[7:0];
      OP_CF_RD: src = {sy2_q[8], 7'h00};
      OP_ID_RD: src = idx_nx == 2'd0 ? MFR_ID : idx_nx == 2'd1 ? DEV_ID[15:8] :
                      idx_nx == 2'd2 ? DEV_ID[7:0] : 8'h00;
      OP_MD_ID: src = (idx_nx[0] ^ addr_q[0]) ? DEV_ID[7:0] : MFR_ID;
      OP_WAKE:  src = ELEC_ID;
      default:  src = array_rdata;
    endcase
  end

  // Output bits are launched on the falling edge and float at frame end.
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      oe_q   <= 1'b0;
      osh_q  <= 8'h00;
      obit_q <= 3'd0;
      idx_q  <= 2'd0;
      ld_q   <= 1'b0;
    end else if (!run) begin
      oe_q <= 1'b0;
      ld_q <= 1'b0;
    end else if (first || lastb) begin
      oe_q   <= 1'b1;
      osh_q  <= src;
      obit_q <= 3'd0;
      idx_q  <= idx_nx;
      ld_q   <= 1'b1;
    end else begin
      osh_q  <= dual_o ? {osh_q[5:0], 2'b00} : {osh_q[6:0], 1'b0};
      obit_q <= obit_q + 3'd1;
      ld_q   <= 1'b0;
    end
  end

  assign io1_o       = osh_q[7];
  assign io0_o       = osh_q[6];
  assign io1_oe      = oe_q;
  assign io0_oe      = oe_q && dual_o;
  assign array_raddr = rptr_q;

  // Core domain: frame end detection and command execution.
  logic        c1_q;
  logic        c2_q;
  logic        c3_q;
  logic        w1_q;
  logic        w2_q;
  logic        tseen_q;
  logic [7:0]  prev_q;
  logic        varm_q;
  logic [23:0] tmr_q;
  logic        op_start_q;
  logic [2:0]  op_kind_q;
  logic [23:0] op_addr_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      c1_q    <= 1'b1;
      c2_q    <= 1'b1;
      c3_q    <= 1'b1;
      w1_q    <= 1'b1;
      w2_q    <= 1'b1;
      tseen_q <= 1'b0;
    end else begin
      c1_q    <= cs_n;
      c2_q    <= c1_q;
      c3_q    <= c2_q;
      w1_q    <= write_guard_pin_n;
      w2_q    <= w1_q;
      tseen_q <= (c2_q && !c3_q) ? tog_q : tseen_q;
    end
  end

  wire        newf   = c2_q && !c3_q && tog_q != tseen_q;
  wire        ok     = newf && lst_q == L_ACT && b3_q == 3'd0;
  wire [4:0]  nb     = n_q[7:3];
  wire        write_enable_latch    = st_q[B_WEL];
  wire        busy   = st_q[B_BUSY];
  wire        lock   = st_q[B_LOCK] && !w2_q;
  wire        tdone  = busy && tmr_q == 24'd1;
  sfcp_kind_t ak;
  assign ak = op_kind_of(op_q);
  wire [48:0] pr     = prot_rng(st_q[6:2]);
  wire [23:0] t_lo   = addr_q & ~tmask(ak);
  wire [23:0] t_hi   = addr_q | tmask(ak);
  wire        hit    = pr[48] && t_lo <= pr[23:0] && t_hi >= pr[47:24];
  wire        len_ok = ak == K_PROG ? nb >= 5'd5 : ak == K_CHIP ? nb == 5'd1 : nb == 5'd4;
  wire        go_arr = ok && ak != K_NONE && ak != K_REG && write_enable_latch && !busy && !hit && len_ok;
  wire        go_sw  = ok && op_q == OP_ST_WR && nb == 5'd2 && !busy && !lock && (write_enable_latch || varm_q);
  wire        go_cw  = ok && op_q == OP_CF_WR && nb == 5'd2 && !busy && write_enable_latch;
  wire        go_rst = ok && op_q == OP_RST && nb == 5'd1 && prev_q == OP_RST_ARM;
  wire        one    = ok && nb == 5'd1;

  // Status register; a later assignment wins, so arming beats completion.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_q <= ST_RST;
    end else begin
      if (tdone) begin
        st_q[B_WEL:B_BUSY] <= 2'b00;
      end
      if (go_arr || go_cw || (go_sw && write_enable_latch)) begin
        st_q[B_BUSY] <= 1'b1;
      end
      if (go_sw) begin
        st_q[7:2] <= dat_q[7:2];
      end
      if (one && op_q == OP_DISARM) begin
        st_q[B_WEL] <= 1'b0;
      end
      if (one && op_q == OP_ARM) begin
        st_q[B_WEL] <= 1'b1;
      end
      if (go_rst) begin
        st_q[B_WEL:B_BUSY] <= 2'b00;
      end
    end
  end

  // Configuration, volatile arm, deep sleep and reset-arm history.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cfg_q  <= CF_RST;
      varm_q <= 1'b0;
      deep_q <= 1'b0;
      prev_q <= 8'h00;
    end else if (newf) begin
      cfg_q  <= go_cw ? {dat_q[B_DC], 7'h00} : cfg_q;
      varm_q <= one && op_q == OP_VARM;
      prev_q <= one ? op_q : 8'h00;
      if (one && op_q == OP_SLEEP) begin
        deep_q <= 1'b1;
      end else if (lst_q == L_ACT && op_q == OP_WAKE) begin
        deep_q <= 1'b0;
      end
    end
  end

  // Self-timed busy counter.
  always_ff @(posedge ref_clk) begin
    if (!rst_b || go_rst || tdone) begin
      tmr_q <= 24'd0;
    end else if (go_arr) begin
      tmr_q <= ak == K_PROG ? 24'(CYC_PROG_P) : 24'(CYC_ERASE_P);
    end else if (go_cw || (go_sw && write_enable_latch)) begin
      tmr_q <= 24'(CYC_STW_P);
    end else if (busy) begin
      tmr_q <= tmr_q - 24'd1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      op_start_q <= 1'b0;
      op_kind_q  <= K_NONE;
      op_addr_q  <= 24'h000000;
    end else begin
      op_start_q <= go_arr;
      op_kind_q  <= go_arr ? ak : op_kind_q;
      op_addr_q  <= go_arr ? t_lo : op_addr_q;
    end
  end

  assign op_start    = op_start_q;
  assign op_kind     = op_kind_q;
  assign op_addr     = op_addr_q;
  assign status_byte = st_q;
  assign config_byte = cfg_q;
  assign deep_sleep  = deep_q;

  property p_arm_needed;
    @(posedge ref_clk) disable iff (!rst_b) op_start_q |-> st_q[B_WEL];
  endproperty
  a_arm_needed: assert property (p_arm_needed) else $error("Operation without latch.");

  property p_busy_set;
    @(posedge ref_clk) disable iff (!rst_b)
      go_arr |=> st_q[B_BUSY] && op_start_q ##1 !op_start_q;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("Busy or start wrong.");

  property p_wel_clear;
    @(posedge ref_clk) disable iff (!rst_b)
      $fell(st_q[B_BUSY]) && !$past(newf) |-> !st_q[B_WEL];
  endproperty
  a_wel_clear: assert property (p_wel_clear) else $error("Latch kept after op.");

  property p_no_busy_start;
    @(posedge ref_clk) disable iff (!rst_b) op_start_q |-> !$past(st_q[B_BUSY]);
  endproperty
  a_no_busy_start: assert property (p_no_busy_start) else $error("Start while busy.");

  property p_prot;
    @(posedge ref_clk) disable iff (!rst_b)
      op_start_q |-> !pr[48] || op_addr_q > pr[23:0] ||
                     (op_addr_q | tmask(sfcp_kind_t'(op_kind_q))) < pr[47:24];
  endproperty
  a_prot: assert property (p_prot) else $error("Protected target started.");

  property p_deep;
    @(posedge ref_clk) disable iff (!rst_b)
      newf && deep_q && op_q != OP_WAKE && !tdone |=> !op_start_q && $stable(st_q[7:1]);
  endproperty
  a_deep: assert property (p_deep) else $error("Command taken in deep sleep.");

  property p_lock;
    @(posedge ref_clk) disable iff (!rst_b) newf && op_q == OP_ST_WR && lock |=> $stable(st_q[7:2]);
  endproperty
  a_lock: assert property (p_lock) else $error("Locked status changed.");

  property p_rst_arm;
    @(posedge ref_clk) disable iff (!rst_b)
      newf && op_q == OP_RST && prev_q != OP_RST_ARM && write_enable_latch && !tdone |=> st_q[B_WEL];
  endproperty
  a_rst_arm: assert property (p_rst_arm) else $error("Unarmed reset acted.");

  property p_boundary;
    @(posedge ref_clk) disable iff (!rst_b)
      newf && op_q == OP_ARM && b3_q != 3'd0 && !write_enable_latch |=> !st_q[B_WEL];
  endproperty
  a_boundary: assert property (p_boundary) else $error("Partial arm accepted.");

  property p_standby_float;
    @(negedge sclk) disable iff (cs_n) io1_oe |-> lst_q == L_ACT;
  endproperty
  a_standby_float: assert property (p_standby_float) else $error("Output in standby.");

endmodule // sfcp_top

// [testbench/sfcp_host_model.sv]
// Host serial controller model: drives one framed transfer at a time.
// Assumes the bench resolves the shared data lines and calls frame().
module sfcp_host_model (
  // Serial link.
  output logic      sclk,
  output logic      cs_n,
  output logic      io0_h,
  input  wire logic io1_w
);
  timeunit 1ns;
  timeprecision 100ps;
  logic cpol;
  initial begin
    cpol = 1'b0;
    sclk = 1'b0;
    io0_h = 1'b0;
    #1 cs_n = 1'b1;
  end
  // Shifts nbits msb first; changes on falling, samples on rising.
  task automatic frame(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
    rx = '0;
    sclk = cpol;
    #10 cs_n = 1'b0;
    #5;
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b0;
      io0_h = tx[63-i];
      #7.5 sclk = 1'b1;
      rx = {rx[62:0], io1_w};
      #7.5;
    end
    if (!cpol) sclk = 1'b0;
    #5 cs_n = 1'b1; // Select rises right after the last bit asked for.
    io0_h = ~io0_h;
    #60;
  endtask
endmodule // sfcp_host_model

// [testbench/tb_sfcp_top.sv]
// Testbench of the serial flash command front end.
// Assumes the host model on the link and a patterned array behind the read port.
module tb_sfcp_top
  import sfcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0]  MFR = 8'h3C;    // Arbitrary value.
  localparam logic [15:0] DEV = 16'h7E21; // Arbitrary value.
  localparam logic [7:0]  ELC = 8'h4D;    // Arbitrary value.
  localparam logic [7:0]  D20 = 8'h20 ^ 8'hA5;
  logic        ref_clk, rst_b, guard_n, sclk, cs_n, io0_h;
  logic        io0_o, io0_oe, io1_o, io1_oe, op_start, deep_sleep;
  logic [23:0] raddr, op_addr, last_addr;
  logic [2:0]  op_kind, last_kind;
  logic [7:0]  status_byte, config_byte;
  logic [63:0] rx;
  wire logic       io0_w = io0_oe ? io0_o : io0_h;
  wire logic       io1_w = io1_oe ? io1_o : ~io0_h;
  wire logic [7:0] rdata = raddr[7:0] ^ 8'hA5;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n_ops = 0;
  int n_oe = 0;
  int n0;

  sfcp_host_model host (.sclk(sclk), .cs_n(cs_n), .io0_h(io0_h), .io1_w(io1_w));
  sfcp_top #(.CYC_PROG_P(20), .CYC_ERASE_P(200), .CYC_STW_P(30), .MFR_ID(MFR),
    .DEV_ID(DEV), .ELEC_ID(ELC)) uut (.ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk),
    .cs_n(cs_n), .io0_i(io0_w), .io0_o(io0_o), .io0_oe(io0_oe), .io1_i(io1_w),
    .io1_o(io1_o), .io1_oe(io1_oe), .write_guard_pin_n(guard_n), .array_raddr(raddr),
    .array_rdata(rdata), .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
    .status_byte(status_byte), .config_byte(config_byte), .deep_sleep(deep_sleep));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge io1_oe) n_oe++;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (op_start === 1'b1) begin
      n_ops <= n_ops + 1;
      last_kind <= op_kind;
      last_addr <= op_addr;
    end
    if (cyc == 30000) begin
      err_total = err_total + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input logic [63:0] tx, input int nbits);
    host.frame(tx, nbits, rx);
  endtask
  task automatic arm();
    send({OP_ARM, 56'h0}, 8);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 400 && status_byte[B_BUSY] !== 1'b0; i++) @(posedge ref_clk);
    chk("idle", 1'b0, status_byte[B_BUSY]);
  endtask

  task automatic t_reset();
    chk("status", ST_RST, status_byte);
    chk("config", CF_RST, config_byte);
    chk("sleep", 1'b0, deep_sleep);
  endtask
  task automatic t_arm();
    arm();
    chk("wel", 1'b1, status_byte[B_WEL]);
    send({OP_ST_RD, 56'h0}, 16);
    chk("status read", 8'h02, rx[7:0]);
    send({OP_DISARM, 56'h0}, 8);
    chk("wel", 1'b0, status_byte[B_WEL]);
    send({OP_ARM, 56'h0}, 9);
    chk("wel", 1'b0, status_byte[B_WEL]);
    send({OP_VARM, 56'h0}, 8);
    chk("wel", 1'b0, status_byte[B_WEL]);
    arm();
    send({OP_RST, 56'h0}, 8);
    chk("wel", 1'b1, status_byte[B_WEL]);
    send({OP_RST_ARM, 56'h0}, 8);
    send({OP_RST, 56'h0}, 8);
    chk("wel", 1'b0, status_byte[B_WEL]);
  endtask
  task automatic t_erase();
    n0 = n_ops;
    send({OP_FULL_BLK, 24'h012345, 32'h0}, 32);
    chk("ops", n0, n_ops);
    arm();
    send({OP_FULL_BLK, 24'h012345, 32'h0}, 31);
    chk("ops", n0, n_ops);
    send({OP_FULL_BLK, 24'h012345, 32'h0}, 32);
    chk("ops", n0 + 1, n_ops);
    chk("kind", K_64K, last_kind);
    chk("addr", 24'h010000, last_addr);
    chk("busy", 1'b1, status_byte[B_BUSY]);
    send({OP_4K_CLR, 24'h000000, 32'h0}, 32);
    chk("ops", n0 + 1, n_ops);
    wait_idle();
    chk("status", 8'h00, status_byte);
    arm();
    send({OP_PAGE_WR, 24'h012345, 8'hAA, 24'h0}, 40);
    chk("kind", K_PROG, last_kind);
    chk("addr", 24'h012300, last_addr);
    wait_idle();
    arm();
    send({OP_CHIP_B, 56'h0}, 8);
    chk("kind", K_CHIP, last_kind);
    wait_idle();
  endtask
  task automatic t_protect();
    arm();
    send({OP_ST_WR, 8'h04, 48'h0}, 16);
    chk("wel busy", 2'b11, status_byte[1:0]);
    wait_idle();
    chk("status", 8'h04, status_byte);
    n0 = n_ops;
    arm();
    send({OP_4K_CLR, 24'h030000, 32'h0}, 32);
    chk("ops", n0, n_ops);
    arm();
    send({OP_4K_CLR, 24'h02F000, 32'h0}, 32);
    chk("ops", n0 + 1, n_ops);
    chk("addr", 24'h02F000, last_addr);
    wait_idle();
    arm();
    send({OP_ST_WR, 8'h84, 48'h0}, 16);
    wait_idle();
    @(posedge ref_clk) guard_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    arm();
    send({OP_ST_WR, 8'h00, 48'h0}, 16);
    wait_idle();
    chk("protect", 6'h21, status_byte[7:2]);
    @(posedge ref_clk) guard_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    arm();
    send({OP_ST_WR, 8'h00, 48'h0}, 16);
    wait_idle();
    chk("status", 8'h00, status_byte);
  endtask
  task automatic t_read();
    send({OP_LP_READ, 24'h000010, 32'h0}, 48);
    chk("read", {8'h10 ^ 8'hA5, 8'h11 ^ 8'hA5}, rx[15:0]);
    send({OP_FAST_READ, 24'h0000F0, 32'h0}, 48);
    chk("fast read", 8'hF0 ^ 8'hA5, rx[7:0]);
    send({OP_DUAL_OUT, 24'h000020, 32'h0}, 44);
    chk("dual read", {D20[7], D20[5], D20[3], D20[1]}, rx[3:0]);
    send({OP_ID_RD, 56'h0}, 32);
    chk("id", {MFR, DEV}, rx[23:0]);
    host.cpol = 1'b1;
    arm();
    chk("wel mode 3", 1'b1, status_byte[B_WEL]);
    send({OP_ID_RD, 56'h0}, 32);
    chk("id mode 3", {MFR, DEV}, rx[23:0]);
    send({OP_DISARM, 56'h0}, 8);
    chk("wel mode 3", 1'b0, status_byte[B_WEL]);
    host.cpol = 1'b0;
    n0 = n_oe;
    send({OP_ST_RD, 56'h0}, 12);
    chk("oe", 1'b0, io1_oe);
    send({8'h4B, 56'h0}, 16);
    chk("oe count", n0 + 1, n_oe);
    send({OP_ST_RD, 56'h0}, 16);
    chk("status read", 8'h00, rx[7:0]);
  endtask
  task automatic t_config();
    arm();
    send({OP_CF_WR, 8'h80, 48'h0}, 16);
    wait_idle();
    chk("config", 8'h80, config_byte);
    send({OP_CF_RD, 56'h0}, 16);
    chk("config read", 8'h80, rx[7:0]);
    send({OP_DUAL_IO, 12'hFFF, 44'h0}, 32);
    chk("dual io read", 4'hC, rx[3:0]);
    send({OP_MD_ID, 24'h000000, 32'h0}, 48);
    chk("maker id", {MFR, DEV[7:0]}, rx[15:0]);
    send({OP_VARM, 56'h0}, 8);
    send({OP_ST_WR, 8'h08, 48'h0}, 16);
    chk("volatile status", 8'h08, status_byte);
    send({OP_VARM, 56'h0}, 8);
    send({OP_ST_WR, 8'h00, 48'h0}, 16);
    chk("status", 8'h00, status_byte);
  endtask
  task automatic t_sleep();
    send({OP_SLEEP, 56'h0}, 8);
    chk("sleep", 1'b1, deep_sleep);
    arm();
    chk("wel", 1'b0, status_byte[B_WEL]);
    send({OP_WAKE, 24'h0, 32'h0}, 40);
    chk("wake id", ELC, rx[7:0]);
    chk("sleep", 1'b0, deep_sleep);
  endtask

  initial begin
    guard_n = 1'b1;
    @(posedge ref_clk) rst_b <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_arm();
    t_erase();
    t_protect();
    t_read();
    t_config();
    t_sleep();
    stop_test();
  end
endmodule // tb_sfcp_top
